// file: rtl/isl_alu.sv
// Execution unit for subtract, swap, test-and-set, trap, bit-test, exclusive-OR and extract.
`timescale 1ns/10ps
// Summary of operation
// - Plain subtract writes destination minus source.
// - Subtract with carry: flag holds borrow.
// - Subtract with overflow flags signed overflow.
// - Byte swap exchanges the two low bytes.
// - Word swap exchanges the two halves.
// - Test-and-set purges cache block before reading.
// - Test-and-set: flag if zero, set bit seven.
// - No interrupt between test-and-set read, write.
// - Atomicity covers only the core's components.
// - Trap raises exception with zero-extended immediate.
// - Trap in delay slot raises illegal slot.
// - Register bit test sets flag on zero.
// - Memory bit test reads, ANDs, never writes.
// - Zero-register plus base address wraps 32 bits.
// - Register XOR writes destination.
// - Immediate XOR writes register zero.
// - Memory XOR reads, XORs, writes back.
// - Extract joins source low, destination high.
module isl_alu
    import isl_pkg::*;
(
    input  wire logic        sys_clk,     // Core clock.
    input  wire logic        arst_n,      // Asynchronous reset, active low.
    input  wire logic        clkEn,       // Freezes all state while low.
    input  wire logic        reqValid,    // Operation issued this cycle.
    input  wire isl_req_t    req,         // Operation and operands.
    input  wire logic        memDone,     // Memory step finished.
    input  wire logic [7:0]  memRdata,    // Byte read from memory.
    input  wire logic        memFault,    // Memory step raised an exception.
    output logic             busy,        // Memory sequence in progress.
    output isl_res_t         res,         // Register and flag update, one cycle.
    output isl_mem_t         mem,         // Memory command, held until done.
    output logic             excValid,    // Exception raised, one cycle.
    output logic [7:0]       excCode,     // Exception kind.
    output logic [7:0]       trapId,      // Trap identifier.
    output logic             irqBlock,    // Interrupt acceptance blocked.
    output logic             condFlag     // Condition flag.
);

    // ------------------------------------------------------------------
    // Combinational datapath
    // ------------------------------------------------------------------
    isl_state_t  state_r, state_nxt;
    isl_op_t     memOp_r;
    logic [7:0]  imm_r;
    logic [31:0] addr_r;
    logic        flag_r;
    isl_res_t    res_r, res_nxt;
    isl_mem_t    mem_r, mem_nxt;
    logic        excValid_r, excValid_nxt;
    logic [7:0]  excCode_r, excCode_nxt;
    logic [7:0]  trapId_r, trapId_nxt;
    logic        irqBlock_r;
    logic        busy_r;
    logic        flag_nxt;
    isl_op_t     memOp_nxt;
    logic [7:0]  imm_nxt;
    logic [31:0] addr_nxt;

    wire logic [32:0] subFull  = {1'b0, req.dstVal} - {1'b0, req.srcVal};
    wire logic [32:0] subcFull = subFull - {32'h0, flag_r};
    wire logic        subvOvf  = (req.dstVal[31] != req.srcVal[31])
                              && (subFull[31] != req.dstVal[31]);
    wire logic [31:0] swapB    = {req.srcVal[31:16], req.srcVal[7:0],
                                  req.srcVal[15:8]};
    wire logic [31:0] swapW    = {req.srcVal[15:0], req.srcVal[31:16]};
    wire logic [31:0] immZx    = {24'h0, req.imm};
    wire logic        tstRR    = ((req.dstVal & req.srcVal) == 32'h0);
    wire logic        tstImm   = ((req.zeroVal & immZx) == 32'h0);
    wire logic [31:0] gbrAddr  = req.zeroVal + req.baseVal;
    wire logic [31:0] xtract   = {req.srcVal[15:0], req.dstVal[31:16]};
    wire logic        isMemOp  = (req.op == OP_TASB) || (req.op == OP_TSTMEM)
                              || (req.op == OP_XORMEM);
    wire logic        issue    = reqValid && (state_r == ST_IDLE);
    wire logic        stepOk   = memDone && !memFault;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        res_nxt      = '0;
        mem_nxt      = mem_r;
        excValid_nxt = 1'b0;
        excCode_nxt  = excCode_r;
        trapId_nxt   = trapId_r;
        flag_nxt     = flag_r;
        memOp_nxt    = memOp_r;
        imm_nxt      = imm_r;
        addr_nxt     = addr_r;
        case (state_r)
            ST_IDLE: begin
                if (issue) begin
                    case (req.op)
                        OP_SUB: begin
                            res_nxt.wrEn   = 1'b1;
                            res_nxt.wrData = subFull[31:0];
                        end
                        OP_SUBTRACT_WITH_CARRY: begin
                            res_nxt.wrEn    = 1'b1;
                            res_nxt.wrData  = subcFull[31:0];
                            res_nxt.flagEn  = 1'b1;
                            res_nxt.flagVal = subcFull[32];
                            flag_nxt        = subcFull[32];
                        end
                        OP_SUBTRACT_WITH_OVERFLOW: begin
                            res_nxt.wrEn    = 1'b1;
                            res_nxt.wrData  = subFull[31:0];
                            res_nxt.flagEn  = 1'b1;
                            res_nxt.flagVal = subvOvf;
                            flag_nxt        = subvOvf;
                        end
                        OP_SWAPB: begin
                            res_nxt.wrEn   = 1'b1;
                            res_nxt.wrData = swapB;
                        end
                        OP_SWAPW: begin
                            res_nxt.wrEn   = 1'b1;
                            res_nxt.wrData = swapW;
                        end
                        OP_TRAP: begin
                            excValid_nxt = 1'b1;
                            excCode_nxt  = req.inSlot ? SLOT_EXC : TRAP_EXC;
                            trapId_nxt   = req.imm;
                        end
                        OP_TSTRR: begin
                            res_nxt.flagEn  = 1'b1;
                            res_nxt.flagVal = tstRR;
                            flag_nxt        = tstRR;
                        end
                        OP_TSTIMM: begin
                            res_nxt.flagEn  = 1'b1;
                            res_nxt.flagVal = tstImm;
                            flag_nxt        = tstImm;
                        end
                        OP_XORRR: begin
                            res_nxt.wrEn   = 1'b1;
                            res_nxt.wrData = req.dstVal ^ req.srcVal;
                        end
                        OP_XORIMM: begin
                            res_nxt.wrZero = 1'b1;
                            res_nxt.wrData = req.zeroVal ^ immZx;
                        end
                        OP_XTRACT: begin
                            res_nxt.wrEn   = 1'b1;
                            res_nxt.wrData = xtract;
                        end
                        default: begin
                        end
                    endcase
                    if (isMemOp) begin
                        memOp_nxt = req.op;
                        imm_nxt   = req.imm;
                        addr_nxt  = (req.op == OP_TASB) ? req.dstVal : gbrAddr;
                        mem_nxt.addr  = addr_nxt;
                        mem_nxt.wdata = 8'h00;
                        if (req.op == OP_TASB) begin
                            mem_nxt.purge = 1'b1;
                            state_nxt     = ST_PURGE;
                        end else begin
                            mem_nxt.rd = 1'b1;
                            state_nxt  = ST_READ;
                        end
                    end
                end
            end
            ST_PURGE: begin
                if (memDone) begin
                    mem_nxt.purge = 1'b0;
                    if (memFault) begin
                        excValid_nxt = 1'b1;
                        excCode_nxt  = ABORT_EXC;
                        state_nxt    = ST_IDLE;
                    end else begin
                        mem_nxt.rd = 1'b1;
                        state_nxt  = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (memDone) begin
                    mem_nxt.rd = 1'b0;
                    if (memFault) begin
                        excValid_nxt = 1'b1;
                        excCode_nxt  = ABORT_EXC;
                        state_nxt    = ST_IDLE;
                    end else if (memOp_r == OP_TSTMEM) begin
                        res_nxt.flagEn  = 1'b1;
                        res_nxt.flagVal = ((memRdata & imm_r) == 8'h00);
                        flag_nxt        = res_nxt.flagVal;
                        state_nxt       = ST_IDLE;
                    end else begin
                        mem_nxt.wr    = 1'b1;
                        mem_nxt.wdata = (memOp_r == OP_TASB)
                                      ? (memRdata | TAS_SET_MASK)
                                      : (memRdata ^ imm_r);
                        flag_nxt      = (memOp_r == OP_TASB) ? (memRdata == 8'h00) : flag_r;
                        state_nxt     = ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (memDone) begin
                    mem_nxt.wr = 1'b0;
                    state_nxt  = ST_IDLE;
                    if (memFault) begin
                        excValid_nxt = 1'b1;
                        excCode_nxt  = ABORT_EXC;
                        flag_nxt     = res_r.flagVal;
                    end else if (memOp_r == OP_TASB) begin
                        res_nxt.flagEn  = 1'b1;
                        res_nxt.flagVal = flag_r;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Held flag before a test-and-set write so an aborted write restores it.
    logic flagHold_r;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= ST_IDLE;
            res_r      <= '0;
            mem_r      <= '0;
            excValid_r <= 1'b0;
            excCode_r  <= 8'h00;
            trapId_r   <= 8'h00;
            flag_r     <= FLAG_RST;
            flagHold_r <= FLAG_RST;
            memOp_r    <= OP_SUB;
            imm_r      <= 8'h00;
            addr_r     <= 32'h0;
            irqBlock_r <= 1'b0;
            busy_r     <= 1'b0;
        end else if (clkEn) begin
            state_r    <= state_nxt;
            res_r      <= res_nxt;
            mem_r      <= mem_nxt;
            excValid_r <= excValid_nxt;
            excCode_r  <= excCode_nxt;
            trapId_r   <= trapId_nxt;
            if (state_r == ST_WRITE && memDone && memFault) begin
                flag_r <= flagHold_r;
            end else begin
                flag_r <= flag_nxt;
            end
            if (state_r == ST_IDLE) begin
                flagHold_r <= flag_r;
            end
            memOp_r    <= memOp_nxt;
            imm_r      <= imm_nxt;
            addr_r     <= addr_nxt;
            irqBlock_r <= (state_nxt != ST_IDLE) && (memOp_nxt == OP_TASB);
            busy_r     <= (state_nxt != ST_IDLE);
        end
    end

    // Busy is loaded from the next state so that it leaves a flip-flop in step with it.
    assign busy     = busy_r;
    assign res      = res_r;
    assign mem      = mem_r;
    assign excValid = excValid_r;
    assign excCode  = excCode_r;
    assign trapId   = trapId_r;
    assign irqBlock = irqBlock_r;
    assign condFlag = flag_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sub_result_a: assert property (clkEn && issue && req.op == OP_SUB |=>
        res.wrEn && res.wrData == $past(req.dstVal) - $past(req.srcVal) && !res.flagEn)
        else $error("subtract result wrong");
    subtract_with_carry_borrow_a: assert property (clkEn && issue && req.op == OP_SUBTRACT_WITH_CARRY |=>
        res.flagVal == $past(subcFull[32]) && condFlag == res.flagVal)
        else $error("borrow flag wrong");
    subtract_with_overflow_ovf_a: assert property (clkEn && issue && req.op == OP_SUBTRACT_WITH_OVERFLOW |=>
        res.flagEn && res.flagVal == $past(subvOvf))
        else $error("overflow flag wrong");
    swapb_val_a: assert property (clkEn && issue && req.op == OP_SWAPB |=>
        res.wrData[15:8] == $past(req.srcVal[7:0]) && res.wrData[7:0] == $past(req.srcVal[15:8]))
        else $error("byte swap wrong");
    swapw_val_a: assert property (clkEn && issue && req.op == OP_SWAPW |=>
        res.wrData == {$past(req.srcVal[15:0]), $past(req.srcVal[31:16])})
        else $error("word swap wrong");
    tas_purge_a: assert property (clkEn && issue && req.op == OP_TASB |=>
        mem.purge && !mem.rd)
        else $error("purge missing before read");
    tas_write_a: assert property (clkEn && state_r == ST_READ && memOp_r == OP_TASB
        && memDone && !memFault |=> mem.wr && mem.wdata[7])
        else $error("test-and-set write wrong");
    tas_irq_a: assert property (mem.wr && memOp_r == OP_TASB |-> irqBlock)
        else $error("interrupt window open");
    trap_id_a: assert property (clkEn && issue && req.op == OP_TRAP |=>
        excValid && trapId == $past(req.imm))
        else $error("trap identifier wrong");
    trap_slot_a: assert property (clkEn && issue && req.op == OP_TRAP && req.inSlot |=>
        excCode == SLOT_EXC)
        else $error("delay slot trap not illegal");
    tstmem_nowr_a: assert property (memOp_r == OP_TSTMEM && busy |-> !mem.wr)
        else $error("bit test wrote memory");
    fault_abort_a: assert property (clkEn && busy && memDone && memFault |=>
        !busy && !res.wrEn && !mem.wr)
        else $error("fault not abandoned");
    xor_reg_a: assert property (clkEn && issue && req.op == OP_XORRR |=>
        res.wrEn && res.wrData == ($past(req.dstVal) ^ $past(req.srcVal)))
        else $error("register exclusive-OR wrong");
    xor_imm_a: assert property (clkEn && issue && req.op == OP_XORIMM |=>
        res.wrZero && res.wrData == ($past(req.zeroVal) ^ {24'h00, $past(req.imm)}))
        else $error("immediate exclusive-OR wrong");
    extract_val_a: assert property (clkEn && issue && req.op == OP_XTRACT |=>
        res.wrData == {$past(req.srcVal[15:0]), $past(req.dstVal[31:16])})
        else $error("half-word extract wrong");
    tas_flag_a: assert property (clkEn && state_r == ST_READ && memOp_r == OP_TASB
        && stepOk |=> condFlag == ($past(memRdata) == 8'h00))
        else $error("test-and-set flag wrong");

    tas_seen_c: cover property (clkEn && state_r == ST_WRITE && memOp_r == OP_TASB && memDone);
    xor_mem_c:  cover property (clkEn && state_r == ST_WRITE && memOp_r == OP_XORMEM && memDone);
    trap_c:     cover property (excValid && excCode == TRAP_EXC);
    slot_c:     cover property (excValid && excCode == SLOT_EXC);
    abort_c:    cover property (excValid && excCode == ABORT_EXC);

endmodule : isl_alu

// file: rtl/isl_pkg.sv
// Package with operation codes, carrier types and constants for the integer ALU tail group.
package isl_pkg;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_SUB      = 4'h0,
        OP_SUBTRACT_WITH_CARRY     = 4'h1,
        OP_SUBTRACT_WITH_OVERFLOW     = 4'h2,
        OP_SWAPB    = 4'h3,
        OP_SWAPW    = 4'h4,
        OP_TASB     = 4'h5,
        OP_TRAP     = 4'h6,
        OP_TSTRR    = 4'h7,
        OP_TSTIMM   = 4'h8,
        OP_TSTMEM   = 4'h9,
        OP_XORRR    = 4'hA,
        OP_XORIMM   = 4'hB,
        OP_XORMEM   = 4'hC,
        OP_XTRACT   = 4'hD
    } isl_op_t;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PURGE  = 3'b001,
        ST_READ   = 3'b010,
        ST_WRITE  = 3'b011
    } isl_state_t;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam int        DATA_W      = 32;
    localparam logic [7:0] TAS_SET_MASK = 8'h80;
    localparam logic [7:0] TRAP_EXC     = 8'h01;
    localparam logic [7:0] SLOT_EXC     = 8'h02;
    localparam logic [7:0] ABORT_EXC    = 8'h03;
    localparam logic       FLAG_RST     = 1'b0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        isl_op_t     op;
        logic [31:0] srcVal;
        logic [31:0] dstVal;
        logic [31:0] zeroVal;
        logic [31:0] baseVal;
        logic [7:0]  imm;
        logic        inSlot;
    } isl_req_t;

    typedef struct packed {
        logic        wrEn;
        logic [31:0] wrData;
        logic        wrZero;
        logic        flagEn;
        logic        flagVal;
    } isl_res_t;

    typedef struct packed {
        logic        purge;
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } isl_mem_t;

endpackage : isl_pkg

// file: testbench/isl_mem_model.sv
// Behavioural byte memory with cache purge that answers the block's memory steps.
`timescale 1ns/10ps
module isl_mem_model
    import isl_pkg::*;
(
    input  wire logic       sys_clk,  // Core clock.
    input  wire logic       arst_n,   // Reset, active low.
    input  wire isl_mem_t   mem,      // Step commanded by the block.
    input  wire logic [1:0] lag,      // Wait cycles before a step ends.
    input  wire logic [1:0] faultAt,  // Step kind that faults, zero for none.
    output logic            memDone,  // Step finished.
    output logic [7:0]      memRdata, // Byte read.
    output logic            memFault  // Step faulted.
);
    logic [7:0] bytes [16];
    logic [1:0] cnt;
    logic [1:0] step;

    assign step = mem.purge ? 2'h1 : (mem.rd ? 2'h2 : (mem.wr ? 2'h3 : 2'h0));

    // Outside a finished step the answer lines carry junk, inverted on idle cycles and held on wait cycles.
    always @(negedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            memDone  <= 1'b0;
            memFault <= 1'b0;
            memRdata <= 8'h00;
            cnt      <= 2'h0;
        end else if (memDone || step == 2'h0) begin
            memDone  <= 1'b0;
            memFault <= ~memFault;
            memRdata <= ~memRdata;
            cnt      <= 2'h0;
        end else if (cnt == lag) begin
            memDone  <= 1'b1;
            memFault <= (faultAt == step);
            memRdata <= (step == 2'h2) ? bytes[mem.addr[3:0]] : ~memRdata;
            if (step == 2'h3 && faultAt != step) begin
                bytes[mem.addr[3:0]] <= mem.wdata;
            end
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule : isl_mem_model

// file: testbench/integer_subtract_logic_test_ops_tb.sv
// Self-checking bench for the subtract, swap, test, trap and exclusive-OR block.
`timescale 1ns/10ps
module integer_subtract_logic_test_ops_tb;
    import isl_pkg::*;

    logic        sys_clk, arst_n, clkEn, reqValid, memDone, memFault, busy;
    logic        excValid, irqBlock, condFlag, expFlag;
    logic [7:0]  memRdata, excCode, trapId;
    logic [1:0]  lag, faultAt;
    logic [31:0] seed;
    isl_req_t    req;
    isl_res_t    res;
    isl_mem_t    mem;
    int          errors, compares, cycles;
    logic [1:0]  stepK [$];
    logic [31:0] stepA [$];
    isl_op_t     ops [11] = '{OP_SUB, OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_WITH_OVERFLOW, OP_SWAPB, OP_SWAPW, OP_TRAP,
                              OP_TSTRR, OP_TSTIMM, OP_XORRR, OP_XORIMM, OP_XTRACT};
    isl_op_t     mops [3] = '{OP_TASB, OP_TSTMEM, OP_XORMEM};

    isl_alu i_isl_alu (
        .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .reqValid(reqValid), .req(req),
        .memDone(memDone), .memRdata(memRdata), .memFault(memFault), .busy(busy), .res(res),
        .mem(mem), .excValid(excValid), .excCode(excCode), .trapId(trapId),
        .irqBlock(irqBlock), .condFlag(condFlag)
    );
    isl_mem_model i_isl_mem_model (
        .sys_clk(sys_clk), .arst_n(arst_n), .mem(mem), .lag(lag), .faultAt(faultAt),
        .memDone(memDone), .memRdata(memRdata), .memFault(memFault)
    );

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (clkEn && memDone && (mem.purge || mem.rd || mem.wr)) begin
            stepK.push_back(mem.purge ? 2'h1 : (mem.rd ? 2'h2 : 2'h3));
            stepA.push_back(mem.addr);
        end
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic final_report();
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    function automatic isl_res_t expReg(input isl_req_t q, inout logic f);
        isl_res_t    r;
        logic [32:0] d;
        r = '0;
        d = {1'b0, q.dstVal} - {1'b0, q.srcVal} - {32'h0, f && q.op == OP_SUBTRACT_WITH_CARRY};
        r.wrEn = q.op inside {OP_SUB, OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_WITH_OVERFLOW, OP_SWAPB, OP_SWAPW, OP_XORRR, OP_XTRACT};
        r.wrZero = q.op == OP_XORIMM;
        r.flagEn = q.op inside {OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_WITH_OVERFLOW, OP_TSTRR, OP_TSTIMM};
        case (q.op)
            OP_SWAPB:  r.wrData = {q.srcVal[31:16], q.srcVal[7:0], q.srcVal[15:8]};
            OP_SWAPW:  r.wrData = {q.srcVal[15:0], q.srcVal[31:16]};
            OP_XORRR:  r.wrData = q.dstVal ^ q.srcVal;
            OP_XORIMM: r.wrData = q.zeroVal ^ {24'h0, q.imm};
            OP_XTRACT: r.wrData = {q.srcVal[15:0], q.dstVal[31:16]};
            default:   r.wrData = d[31:0];
        endcase
        case (q.op)
            OP_SUBTRACT_WITH_CARRY:   f = d[32];
            OP_SUBTRACT_WITH_OVERFLOW:   f = (q.dstVal[31] != q.srcVal[31]) && (d[31] != q.dstVal[31]);
            OP_TSTRR:  f = (q.dstVal & q.srcVal) == 32'h0;
            OP_TSTIMM: f = (q.zeroVal[7:0] & q.imm) == 8'h0;
            default:   f = f;
        endcase
        return r;
    endfunction : expReg

    // Leaves the request raised so that register operations follow back to back.
    task automatic regOp(input isl_op_t op, input logic [31:0] s, d, z, input logic [7:0] im,
                         input logic sl);
        isl_res_t e;
        req      = '{op, s, d, z, rnd(), im, sl};
        reqValid = 1'b1;
        e        = expReg(req, expFlag);
        @(negedge sys_clk);
        chk("wrEn", {31'h0, e.wrEn}, {31'h0, res.wrEn});
        chk("wrZero", {31'h0, e.wrZero}, {31'h0, res.wrZero});
        if (e.wrEn || e.wrZero)
            chk("wrData", e.wrData, res.wrData);
        chk("flagEn", {31'h0, e.flagEn}, {31'h0, res.flagEn});
        chk("condFlag", {31'h0, expFlag}, {31'h0, condFlag});
        chk("excValid", {31'h0, op == OP_TRAP}, {31'h0, excValid});
        if (op == OP_TRAP)
            chk("excCode", {24'h0, sl ? SLOT_EXC : TRAP_EXC}, {24'h0, excCode});
        if (op == OP_TRAP && !sl)
            chk("trapId", {24'h0, im}, {24'h0, trapId});
    endtask : regOp

    task automatic memOp(input isl_op_t op, input logic [31:0] a, b, input logic [7:0] im,
                         init, input logic [1:0] flt, dl);
        logic [31:0] ad;
        logic [7:0]  wb, eb, code;
        logic [1:0]  kd [3];
        int          ne;
        logic        bad, lost;
        isl_res_t    got;
        ad = (op == OP_TASB) ? a : a + b;
        wb = (op == OP_TASB) ? (init | TAS_SET_MASK) : (init ^ im);
        case (op)
            OP_TASB:   kd = '{2'h1, 2'h2, 2'h3};
            OP_TSTMEM: kd = '{2'h2, 2'h0, 2'h0};
            default:   kd = '{2'h2, 2'h3, 2'h0};
        endcase
        ne = 0;
        while (ne < 3 && kd[ne] != 2'h0 && (ne == 0 || kd[ne - 1] != flt))
            ne++;
        bad = flt != 2'h0 && (kd[0] == flt || kd[1] == flt || kd[2] == flt);
        eb = (bad || op == OP_TSTMEM) ? init : wb;
        got = '0;
        code = 8'h00;
        lost = 1'b0;
        lag = dl;
        faultAt = flt;
        i_isl_mem_model.bytes[ad[3:0]] = init;
        stepK.delete();
        stepA.delete();
        req = '{op, 32'h0, a, a, b, im, 1'b0};
        reqValid = 1'b1;
        @(negedge sys_clk);
        req.op = OP_SUB;
        for (int n = 0; n < 60 && (n < 2 || busy === 1'b1); n++) begin
            @(negedge sys_clk);
            // One frozen cycle on single-wait steps makes the memory repeat a missed answer.
            clkEn = !(dl == 2'h1 && n == 0);
            if (n == 0)
                reqValid = 1'b0;
            if (res.wrEn || res.wrZero || res.flagEn)
                got = res;
            if (excValid)
                code = excCode;
            if (op == OP_TASB && busy !== irqBlock)
                lost = 1'b1;
        end
        if (!bad && op != OP_XORMEM)
            expFlag = (op == OP_TASB) ? (init == 8'h00) : ((init & im) == 8'h00);
        chk("steps", ne, stepK.size());
        foreach (stepK[k]) begin
            chk("stepKind", {30'h0, kd[k % 3]}, {30'h0, stepK[k]});
            chk("stepAddr", ad, stepA[k]);
        end
        chk("memByte", {24'h0, eb}, {24'h0, i_isl_mem_model.bytes[ad[3:0]]});
        chk("regWrite", 32'h0, {31'h0, got.wrEn | got.wrZero});
        chk("flagEn", {31'h0, !bad && op != OP_XORMEM}, {31'h0, got.flagEn});
        chk("condFlag", {31'h0, expFlag}, {31'h0, condFlag});
        chk("abort", {24'h0, bad ? ABORT_EXC : 8'h00}, {24'h0, code});
        chk("atomic", 32'h0, {31'h0, lost});
    endtask : memOp

    initial begin
        logic [31:0] s;
        logic [31:0] z;
        sys_clk = 1'b0;
        arst_n = 1'b0;
        clkEn = 1'b1;
        reqValid = 1'b0;
        req = '0;
        lag = 2'h0;
        faultAt = 2'h0;
        seed = 32'd35;
        expFlag = FLAG_RST;
        errors = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        regOp(OP_SUBTRACT_WITH_OVERFLOW, 32'h0000_0001, 32'h8000_0000, 32'h0, 8'h00, 1'b0);
        regOp(OP_SUBTRACT_WITH_OVERFLOW, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0, 8'h00, 1'b0);
        regOp(OP_SUBTRACT_WITH_OVERFLOW, 32'h0000_0001, 32'h7FFF_FFFF, 32'h0, 8'h00, 1'b0);
        regOp(OP_SUBTRACT_WITH_CARRY, 32'h0000_0001, 32'h0000_0000, 32'h0, 8'h00, 1'b0);
        regOp(OP_SUBTRACT_WITH_CARRY, 32'h0000_0005, 32'h0000_0006, 32'h0, 8'h00, 1'b0);
        regOp(OP_TRAP, 32'h0, 32'h0, 32'h0, 8'hFF, 1'b0);
        regOp(OP_TRAP, 32'h0, 32'h0, 32'h0, 8'h5A, 1'b1);
        for (int i = 0; i < 600; i++) begin
            s = rnd();
            z = rnd();
            regOp(ops[rnd() % 11], s, (i % 3 == 0) ? ~s : rnd(), z,
                  (i % 4 == 0) ? ~z[7:0] : 8'(rnd()), rnd() % 5 == 0);
        end
        reqValid = 1'b0;
        @(negedge sys_clk);
        memOp(OP_TASB, 32'h0000_0013, 32'h0, 8'h00, 8'h00, 2'h0, 2'h0);
        memOp(OP_TASB, 32'h0000_0024, 32'h0, 8'h00, 8'h5A, 2'h0, 2'h2);
        memOp(OP_TASB, 32'h0000_0035, 32'h0, 8'h00, 8'h00, 2'h3, 2'h1);
        memOp(OP_TASB, 32'h0000_0046, 32'h0, 8'h00, 8'h00, 2'h1, 2'h0);
        memOp(OP_TSTMEM, 32'hFFFF_FFF8, 32'h0000_000C, 8'hC3, 8'h3C, 2'h0, 2'h1);
        memOp(OP_TSTMEM, 32'hFFFF_FFF8, 32'h0000_000C, 8'h04, 8'h3C, 2'h2, 2'h0);
        memOp(OP_XORMEM, 32'hFFFF_FFFF, 32'h0000_0002, 8'hFF, 8'hA5, 2'h0, 2'h3);
        memOp(OP_XORMEM, 32'h0000_0010, 32'h0000_0007, 8'h0F, 8'h81, 2'h3, 2'h0);
        for (int i = 0; i < 24; i++) begin
            s = rnd();
            memOp(mops[i % 3], s, rnd(), 8'(rnd()), (i % 4 == 0) ? 8'h00 : s[7:0],
                  2'h0, 2'(i));
        end
        final_report();
    end
endmodule : integer_subtract_logic_test_ops_tb
